// ---- include/srfa_defs.vh ----
`ifndef SRFA_DEFS_VH
`define SRFA_DEFS_VH

// ==========================================================
// Frame layout
// ==========================================================
`define SRFA_ADDR_W        15
`define SRFA_DATA_W        8
`define SRFA_FRAME_BITS    24
`define SRFA_FRAME_LAST    5'd23
`define SRFA_INSTR_LAST    5'd15
`define SRFA_RW_READ       1'b1
`define SRFA_RW_WRITE      1'b0

// ==========================================================
// Operation codes
// ==========================================================
`define SRFA_OP_BATCH_READ  2'h0
`define SRFA_OP_FIELD_WRITE 2'h1
`define SRFA_OP_FIELD_READ  2'h2

// ==========================================================
// List sizes and field limits
// ==========================================================
`define SRFA_LIST_DEPTH    16
`define SRFA_LIST_MAX      5'h10
`define SRFA_POS_MAX       4'h7

// ==========================================================
// Timing
// ==========================================================
`define SRFA_CLK_PERIOD_NS 10
`define SRFA_SCLK_HALF_NS  20
`define SRFA_SCLK_HALF_CYC ((`SRFA_SCLK_HALF_NS + `SRFA_CLK_PERIOD_NS - 1) / `SRFA_CLK_PERIOD_NS)

`endif

// ---- core/srfa_spi_shift.v ----
`timescale 1ns/1ps
`include "srfa_defs.vh"

module srfa_spi_shift (
   input  wire        sys_clk,      // System clock
   input  wire        sys_rst,      // Synchronous reset, high
   input  wire        start,        // Start one frame
   input  wire        start_rd,     // Frame is a read
   input  wire [14:0] start_addr,   // Register address
   input  wire [7:0]  start_wdata,  // Write data byte
   input  wire        mode_3wire,   // 3-wire wiring selected
   input  wire        sdio_in,      // Data pin level
   input  wire        sdo_in,       // Separate output pin of device
   output reg         sclk_r,       // Serial clock
   output reg         csb_r,        // Chip select, low active
   output reg         sdio_out_r,   // Data pin drive value
   output reg         sdio_oe_n_r,  // Data pin enable, low drives
   output reg         done_r,       // Frame finished pulse
   output reg  [7:0]  rdata_r       // Byte read in last frame
);

   localparam integer HALF_LAST_I = `SRFA_SCLK_HALF_CYC - 1;
   localparam [3:0]   HALF_LAST   = HALF_LAST_I[3:0];

   reg        active_r;
   reg [23:0] tx_r;
   reg [7:0]  rx_r;
   reg [4:0]  bit_r;
   reg [3:0]  div_r;
   reg        rd_r;

   // ==========================================================
   // Frame shifter: change on falling edge, sample on rising
   // ==========================================================
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         active_r    <= 1'b0;
         tx_r        <= 24'h000000;
         rx_r        <= 8'h00;
         bit_r       <= 5'h00;
         div_r       <= 4'h0;
         rd_r        <= 1'b0;
         sclk_r      <= 1'b0;
         csb_r       <= 1'b1;
         sdio_out_r  <= 1'b0;
         sdio_oe_n_r <= 1'b1;
         done_r      <= 1'b0;
         rdata_r     <= 8'h00;
      end else begin
         done_r <= 1'b0;
         if (!active_r) begin
            if (start) begin
               active_r    <= 1'b1;
               csb_r       <= 1'b0;
               // Read/write flag on top of 15-bit address, one data byte
               tx_r        <= {start_rd, start_addr, start_wdata};   // [RULE1] [RULE2]
               sdio_out_r  <= start_rd;
               sdio_oe_n_r <= 1'b0;
               bit_r       <= 5'h00;
               div_r       <= 4'h0;
               rd_r        <= start_rd;
            end
         end else if (div_r == HALF_LAST) begin
            div_r <= 4'h0;
            if (!sclk_r) begin
               sclk_r <= 1'b1;
               // Read pin follows the wiring mode
               rx_r   <= {rx_r[6:0], mode_3wire ? sdio_in : sdo_in};  // [RULE12]
            end else begin
               sclk_r <= 1'b0;
               if (bit_r == `SRFA_FRAME_LAST) begin
                  active_r    <= 1'b0;
                  csb_r       <= 1'b1;
                  sdio_oe_n_r <= 1'b1;
                  done_r      <= 1'b1;
                  rdata_r     <= rx_r;
               end else begin
                  bit_r       <= bit_r + 5'h01;
                  tx_r        <= {tx_r[22:0], 1'b0};
                  sdio_out_r  <= tx_r[22];
                  // Release shared pin for read data in 3-wire mode
                  sdio_oe_n_r <= rd_r && mode_3wire && (bit_r >= `SRFA_INSTR_LAST);  // [RULE12]
               end
            end
         end else begin
            div_r <= div_r + 4'h1;
         end
      end
   end

endmodule // srfa_spi_shift

// ---- core/srfa_host_ctrl.v ----
`timescale 1ns/1ps
`include "srfa_defs.vh"

// Function
// RULE1 - Each access carries a 15-bit register address and moves exactly one 8-bit byte.
// RULE2 - The instruction MSB is the read/write flag, so an address wider than 15 bits is refused.
// RULE3 - A batched read stores the byte of each listed address at the same list index.
// RULE4 - A batched read performs exactly as many reads as the given count.
// RULE5 - A batched read is carried out as separate single-register reads, one per entry.
// RULE6 - A field write reads the whole byte, changes only the field bits and writes it back to the same address.
// RULE7 - The new byte is the old byte with mask bits cleared, ORed with the shifted field value limited to the mask.
// RULE8 - The field position is limited to 0 through 7.
// RULE9 - A field read is a single register read with no write.
// RULE10 - A field read returns the masked byte shifted right by the field position.
// RULE11 - The mask is applied to the full byte read before extraction or modification.
// RULE12 - Controller and device use the same 3-wire or 4-wire wiring mode.
// RULE13 - Each operation reports success or error, and the next one is accepted only after that.
module srfa_host_ctrl (
   input  wire        sys_clk,             // System clock, 100 MHz
   input  wire        sys_rst,             // Synchronous reset, high
   input  wire        mode_3wire,          // 1: 3-wire, 0: 4-wire
   input  wire        cmd_valid,           // Operation request
   input  wire [1:0]  cmd_op,              // Operation code
   input  wire [15:0] cmd_addr,            // Register address, field ops
   input  wire [4:0]  cmd_count,           // Batched read count
   input  wire [7:0]  field_value,         // New field value
   input  wire [7:0]  field_mask,          // Field mask
   input  wire [3:0]  field_lsb_position,  // Field LSB index
   input  wire        list_wr_en,          // Address list write
   input  wire [3:0]  list_wr_idx,         // Address list index
   input  wire [15:0] list_wr_addr,        // Address list entry
   input  wire [3:0]  res_rd_idx,          // Result list index
   input  wire        spi_sdio_in,         // Data pin level
   input  wire        spi_sdo,             // Device output pin, 4-wire
   output reg         cmd_ready_r,         // Ready for a request
   output reg         op_done_r,           // Status pulse
   output reg         op_err_r,            // Error with status pulse
   output reg  [7:0]  field_value_out_r,   // Extracted field
   output reg  [7:0]  res_rd_data_r,       // Result list byte
   output wire        spi_sclk,            // Serial clock
   output wire        spi_csb,             // Chip select, low
   output wire        spi_sdio_out,        // Data pin drive value
   output wire        spi_sdio_oe_n        // Data pin enable, low drives
);

   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_READ  = 5'h02;
   localparam [4:0] ST_RWAIT = 5'h04;
   localparam [4:0] ST_WRITE = 5'h08;
   localparam [4:0] ST_WWAIT = 5'h10;

   reg [15:0] addr_mem [0:`SRFA_LIST_DEPTH-1];
   reg [7:0]  res_mem  [0:`SRFA_LIST_DEPTH-1];
   reg [4:0]  state_r;
   reg [1:0]  op_r;
   reg [4:0]  idx_r;
   reg [4:0]  cnt_r;
   reg [14:0] addr_r;
   reg [7:0]  fval_r;
   reg [7:0]  mask_r;
   reg [2:0]  pos_r;
   reg        spi_start_r;
   reg        spi_rd_r;
   reg [14:0] spi_addr_r;
   reg [7:0]  spi_wdata_r;
   reg        cmd_bad;

   wire       spi_done;
   wire [7:0] spi_rdata;
   wire [15:0] list_addr = addr_mem[idx_r[3:0]];

   // ==========================================================
   // Address list and result list
   // ==========================================================
   // List loading and result readout
   always @(posedge sys_clk) begin
      if (list_wr_en) begin
         addr_mem[list_wr_idx] <= list_wr_addr;
      end
      res_rd_data_r <= res_mem[res_rd_idx];
   end

   // Request checks
   always @* begin
      cmd_bad = 1'b0;
      case (cmd_op)
         `SRFA_OP_BATCH_READ: begin
            cmd_bad = (cmd_count == 5'h00) || (cmd_count > `SRFA_LIST_MAX);   // [RULE4]
         end
         `SRFA_OP_FIELD_WRITE, `SRFA_OP_FIELD_READ: begin
            cmd_bad = cmd_addr[15] || (field_lsb_position > `SRFA_POS_MAX);  // [RULE2] [RULE8]
         end
         default: begin
            cmd_bad = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // Operation sequencer
   // ==========================================================
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r           <= ST_IDLE;
         op_r              <= `SRFA_OP_BATCH_READ;
         idx_r             <= 5'h00;
         cnt_r             <= 5'h00;
         addr_r            <= 15'h0000;
         fval_r            <= 8'h00;
         mask_r            <= 8'h00;
         pos_r             <= 3'h0;
         spi_start_r       <= 1'b0;
         spi_rd_r          <= 1'b0;
         spi_addr_r        <= 15'h0000;
         spi_wdata_r       <= 8'h00;
         cmd_ready_r       <= 1'b1;
         op_done_r         <= 1'b0;
         op_err_r          <= 1'b0;
         field_value_out_r <= 8'h00;
      end else begin
         op_done_r   <= 1'b0;
         spi_start_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (cmd_valid && cmd_ready_r) begin
                  op_r   <= cmd_op;
                  idx_r  <= 5'h00;
                  cnt_r  <= cmd_count;
                  addr_r <= cmd_addr[14:0];
                  fval_r <= field_value;
                  mask_r <= field_mask;
                  pos_r  <= field_lsb_position[2:0];
                  op_err_r <= cmd_bad;
                  if (cmd_bad) begin
                     // Refused request still gets a status
                     op_done_r <= 1'b1;                                   // [RULE13]
                  end else begin
                     cmd_ready_r <= 1'b0;                                 // [RULE13]
                     state_r     <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               if (op_r == `SRFA_OP_BATCH_READ && list_addr[15]) begin
                  // List entry wider than 15 bits ends the batch
                  op_err_r    <= 1'b1;                                    // [RULE2]
                  op_done_r   <= 1'b1;
                  cmd_ready_r <= 1'b1;
                  state_r     <= ST_IDLE;
               end else begin
                  // One single-register read per entry or field op
                  spi_start_r <= 1'b1;                                    // [RULE5] [RULE9]
                  spi_rd_r    <= `SRFA_RW_READ;
                  spi_addr_r  <= (op_r == `SRFA_OP_BATCH_READ) ? list_addr[14:0] : addr_r;
                  state_r     <= ST_RWAIT;
               end
            end
            ST_RWAIT: begin
               if (spi_done) begin
                  case (op_r)
                     `SRFA_OP_BATCH_READ: begin
                        res_mem[idx_r[3:0]] <= spi_rdata;                 // [RULE3]
                        if (idx_r == cnt_r - 5'h01) begin
                           op_done_r   <= 1'b1;                           // [RULE4] [RULE13]
                           cmd_ready_r <= 1'b1;
                           state_r     <= ST_IDLE;
                        end else begin
                           idx_r   <= idx_r + 5'h01;
                           state_r <= ST_READ;
                        end
                     end
                     `SRFA_OP_FIELD_WRITE: begin
                        // Merge field into full byte read back
                        spi_wdata_r <= (spi_rdata & ~mask_r) | ((fval_r << pos_r) & mask_r);  // [RULE6] [RULE7] [RULE11]
                        state_r     <= ST_WRITE;
                     end
                     default: begin
                        // Extract field, no write issued
                        field_value_out_r <= (spi_rdata & mask_r) >> pos_r;  // [RULE10] [RULE11] [RULE9]
                        op_done_r         <= 1'b1;                        // [RULE13]
                        cmd_ready_r       <= 1'b1;
                        state_r           <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_WRITE: begin
               // Write back to the same address
               spi_start_r <= 1'b1;                                       // [RULE6]
               spi_rd_r    <= `SRFA_RW_WRITE;
               spi_addr_r  <= addr_r;
               state_r     <= ST_WWAIT;
            end
            ST_WWAIT: begin
               if (spi_done) begin
                  op_done_r   <= 1'b1;                                    // [RULE13]
                  cmd_ready_r <= 1'b1;
                  state_r     <= ST_IDLE;
               end
            end
            default: begin
               state_r     <= ST_IDLE;
               cmd_ready_r <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Serial frame engine
   // ==========================================================
   srfa_spi_shift u_shift (
      .sys_clk     (sys_clk),
      .sys_rst     (sys_rst),
      .start       (spi_start_r),
      .start_rd    (spi_rd_r),
      .start_addr  (spi_addr_r),
      .start_wdata (spi_wdata_r),
      .mode_3wire  (mode_3wire),
      .sdio_in     (spi_sdio_in),
      .sdo_in      (spi_sdo),
      .sclk_r      (spi_sclk),
      .csb_r       (spi_csb),
      .sdio_out_r  (spi_sdio_out),
      .sdio_oe_n_r (spi_sdio_oe_n),
      .done_r      (spi_done),
      .rdata_r     (spi_rdata)
   );

endmodule // srfa_host_ctrl

// ---- bench/srfa_spi_dev.sv ----
`timescale 1ns/1ps
// ==========================================================
// Register port of the far device, SPI mode 0
module srfa_spi_dev (
   input  wire sclk,   // Serial clock
   input  wire csb,    // Select, low active
   input  wire sdi,    // Resolved data line
   output reg  sdo_r   // Read data, scrambled when idle
);
   reg [7:0]  mem [0:255];  // Register file
   reg [15:0] instr_r;      // Read flag and address
   reg [7:0]  wdat_r;       // Write byte
   reg [14:0] last_wr;      // Last written address
   integer    cnt, n_rd, n_wr, i;
   // Known start values
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h3c;
      cnt = 0;
      n_rd = 0;
      n_wr = 0;
      sdo_r = 1'b0;
   end
   // New frame at select
   always @(negedge csb) cnt = 0;
   // 16-bit instruction, flag in MSB, then one byte, MSB first
   always @(posedge sclk) begin
      if (!csb) begin
         if (cnt < 16) instr_r = {instr_r[14:0], sdi};
         else wdat_r = {wdat_r[6:0], sdi};
         cnt = cnt + 1;
         if (cnt == 24 && instr_r[15]) n_rd = n_rd + 1;
         else if (cnt == 24) begin
            n_wr = n_wr + 1;
            mem[instr_r[7:0]] = wdat_r;
            last_wr = instr_r[14:0];
         end
      end
   end
   // Read bits after falling edges; garbage once released
   always @(negedge sclk or posedge csb)
      if (!csb && instr_r[15] && cnt >= 16 && cnt < 24) sdo_r <= mem[instr_r[7:0]][23 - cnt];
      else sdo_r <= ~sdo_r;
endmodule // srfa_spi_dev

// ---- bench/srfa_host_ctrl_chk.sv ----
`timescale 1ns/1ps
// ==========================================================
// Command and frame checker
module srfa_host_ctrl_chk (
   input wire        sys_clk,            // Clock
   input wire        sys_rst,            // Reset
   input wire        cmd_valid,          // Request
   input wire [1:0]  cmd_op,             // Operation
   input wire [15:0] cmd_addr,           // Address
   input wire [4:0]  cmd_count,          // Batch count
   input wire [3:0]  field_lsb_position, // Field position
   input wire        cmd_ready_r,        // Idle
   input wire        op_done_r,          // Status pulse
   input wire        op_err_r,           // Error flag
   input wire        spi_sclk,           // Serial clock
   input wire        spi_csb,            // Select
   input wire        spi_sdio_oe_n       // Data enable
);
   reg [5:0] rise_cnt_r;  // Sclk rises in frame
   // Count sclk rises inside a frame
   always @(posedge sys_clk)
      if (sys_rst || spi_csb) rise_cnt_r <= 6'h0;
      else if ($rose(spi_sclk)) rise_cnt_r <= rise_cnt_r + 6'h1;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_take;
      cmd_valid && cmd_ready_r;
   endsequence
   sequence s_fail;
      op_done_r && op_err_r;
   endsequence
   a_take_drop: assert property (s_take |=> !cmd_ready_r || op_done_r) else $error("request not taken");
   a_done_pulse: assert property (op_done_r |=> !op_done_r) else $error("status pulse too long");
   a_done_ready: assert property (op_done_r |-> cmd_ready_r) else $error("not ready at status");
   a_idle_quiet: assert property (cmd_ready_r |-> spi_csb && !spi_sclk && spi_sdio_oe_n) else $error("bus busy idle");
   a_frame_bits: assert property ($rose(spi_csb) |-> rise_cnt_r == 6'h18) else $error("frame not 24 bits");
   a_addr_err: assert property (s_take ##0 cmd_op != 2'h0 && cmd_addr[15] |=> s_fail) else $error("wide address");
   a_pos_err: assert property (s_take ##0 cmd_op != 2'h0 && field_lsb_position > 4'h7 |=> s_fail) else $error("bad pos");
   a_count_err: assert property (s_take ##0 cmd_op == 2'h0 && (cmd_count == 5'h0 || cmd_count > 5'h10) |=> s_fail)
      else $error("bad count accepted");
endmodule // srfa_host_ctrl_chk

// ---- bench/srfa_host_ctrl_bench.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench top
module srfa_host_ctrl_bench;
   reg        sys_clk, sys_rst, mode_3wire, cmd_valid, list_wr_en, err_seen;
   reg [1:0]  cmd_op;
   reg [15:0] cmd_addr, list_wr_addr;
   reg [4:0]  cmd_count;
   reg [7:0]  field_value, field_mask;
   reg [3:0]  field_lsb_position, list_wr_idx, res_rd_idx;
   wire       cmd_ready_r, op_done_r, op_err_r, spi_sclk, spi_csb, spi_sdio_out, spi_sdio_oe_n, dev_d;
   wire [7:0] field_value_out_r, res_rd_data_r;
   wire       spi_sdio_in = spi_sdio_oe_n ? dev_d : spi_sdio_out;
   integer    n_errors, n_tests, n0, w0, i;
   reg [7:0]  d_rd, d_wr;  // Frames seen in the last operation
   srfa_host_ctrl u_srfa_host_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_3wire(mode_3wire),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_count(cmd_count), .field_value(field_value),
      .field_mask(field_mask), .field_lsb_position(field_lsb_position), .list_wr_en(list_wr_en),
      .list_wr_idx(list_wr_idx), .list_wr_addr(list_wr_addr), .res_rd_idx(res_rd_idx), .spi_sdio_in(spi_sdio_in),
      .spi_sdo(dev_d), .cmd_ready_r(cmd_ready_r), .op_done_r(op_done_r), .op_err_r(op_err_r),
      .field_value_out_r(field_value_out_r), .res_rd_data_r(res_rd_data_r), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
      .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_n(spi_sdio_oe_n));
   srfa_spi_dev u_dev (.sclk(spi_sclk), .csb(spi_csb), .sdi(spi_sdio_in), .sdo_r(dev_d));
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task tick;
      begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   task chk(input string nm, input [15:0] exp, input [15:0] got);
      begin
         n_tests++;
         if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task complete_run;
      begin
         $display("Checks %0d, errors %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   // One request, bounded wait for status
   task do_op(input [1:0] op, input [15:0] a, input [4:0] c, input [7:0] v, input [7:0] m, input [3:0] p);
      integer k;
      begin
         tick;
         {cmd_op, cmd_addr, cmd_count} = {op, a, c};
         {field_value, field_mask, field_lsb_position} = {v, m, p};
         n0 = u_dev.n_rd;
         w0 = u_dev.n_wr;
         cmd_valid = 1'b1;
         tick;
         cmd_valid = 1'b0;
         for (k = 0; k < 4000 && op_done_r !== 1'b1; k = k + 1) tick;
         if (k == 4000) begin
            n_errors++;
            $display("[ERR] op_done_r expected 1 seen 0");
            complete_run;
         end
         err_seen = op_err_r;
         d_rd = u_dev.n_rd - n0;
         d_wr = u_dev.n_wr - w0;
      end
   endtask
   task set_list(input [3:0] ix, input [15:0] a);
      begin
         {list_wr_en, list_wr_idx, list_wr_addr} = {1'b1, ix, a};
         tick;
         list_wr_en = 1'b0;
         tick;
      end
   endtask
   // Full 16-entry batch, results by index
   task t_batch;
      begin
         for (i = 0; i < 16; i = i + 1) set_list(i[3:0], {8'h00, i[3:0], 4'h3});
         do_op(2'h0, 16'h0, 5'h10, 8'h0, 8'h0, 4'h0);
         chk("batch err", 16'h0, {15'h0, err_seen});
         chk("batch reads", 16'h10, u_dev.n_rd - n0);
         for (i = 0; i < 16; i = i + 1) begin
            res_rd_idx = i[3:0];
            tick;
            tick;
            chk("batch byte", {8'h0, i[3:0], 4'h3} ^ 16'h3c, res_rd_data_r);
         end
      end
   endtask
   // Read-modify-write of one field
   task t_fwrite(input [15:0] a, input [7:0] v, input [7:0] m, input [3:0] p, input [7:0] old);
      begin
         do_op(2'h1, a, 5'h1, v, m, p);
         chk("fw err", 16'h0, {15'h0, err_seen});
         chk("fw frames", 16'h0101, {d_rd, d_wr});
         chk("fw addr", a, {1'b0, u_dev.last_wr});
         chk("fw byte", (old & ~m) | ((v << p) & m), u_dev.mem[a[7:0]]);
      end
   endtask
   // Single read, field shifted down
   task t_fread(input [15:0] a, input [7:0] m, input [3:0] p, input md, input [7:0] rv);
      begin
         mode_3wire = md;
         tick;
         do_op(2'h2, a, 5'h1, 8'h0, m, p);
         chk("fr frames", 16'h0100, {d_rd, d_wr});
         chk("fr value", (rv & m) >> p, field_value_out_r);
      end
   endtask
   // Refused request: error status, no frame
   task t_bad(input [1:0] op, input [15:0] a, input [4:0] c, input [3:0] p);
      begin
         do_op(op, a, c, 8'h0, 8'hff, p);
         chk("bad err", 16'h1, {15'h0, err_seen});
         chk("bad frames", 16'h0, u_dev.n_rd - n0 + u_dev.n_wr - w0);
      end
   endtask
   // Wide entry stops batch, earlier results kept
   task t_list_bad;
      begin
         set_list(4'h0, 16'h0040);
         set_list(4'h1, 16'h0041);
         set_list(4'h2, 16'h8001);
         do_op(2'h0, 16'h0, 5'h4, 8'h0, 8'h0, 4'h0);
         chk("list err", 16'h1, {15'h0, err_seen});
         chk("list reads", 16'h2, u_dev.n_rd - n0);
         res_rd_idx = 4'h1;
         tick;
         tick;
         chk("list byte", 16'h7d, res_rd_data_r);
      end
   endtask
   // Main sequence
   initial begin
      {sys_rst, mode_3wire, cmd_valid, list_wr_en} = 4'b1000;
      {cmd_op, cmd_addr, cmd_count, field_value, field_mask} = 39'h0;
      {field_lsb_position, list_wr_idx, list_wr_addr, res_rd_idx} = 28'h0;
      n_errors = 0;
      n_tests = 0;
      repeat (12) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      t_batch;
      t_fwrite(16'h0021, 8'h05, 8'h1c, 4'h2, 8'h1d);
      t_fwrite(16'h0022, 8'hff, 8'h30, 4'h4, 8'h1e);
      t_fread(16'h0021, 8'h1c, 4'h2, 1'b1, 8'h15);
      t_fread(16'h00b0, 8'h80, 4'h7, 1'b0, 8'h8c);
      t_bad(2'h2, 16'h8012, 5'h1, 4'h0);
      t_bad(2'h1, 16'h0012, 5'h1, 4'h8);
      t_bad(2'h0, 16'h0000, 5'h0, 4'h0);
      t_bad(2'h0, 16'h0000, 5'h11, 4'h0);
      t_bad(2'h3, 16'h0000, 5'h1, 4'h0);
      t_list_bad;
      complete_run;
   end
endmodule // srfa_host_ctrl_bench
bind srfa_host_ctrl srfa_host_ctrl_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
   .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_count(cmd_count), .field_lsb_position(field_lsb_position),
   .cmd_ready_r(cmd_ready_r), .op_done_r(op_done_r), .op_err_r(op_err_r), .spi_sclk(spi_sclk),
   .spi_csb(spi_csb), .spi_sdio_oe_n(spi_sdio_oe_n));
